/* File: rlt_timer.sv */
// Reloadable up-counting timer: one-shot, triggered, continuous and event counter modes
// Function
// - One-shot counts prescaled clocks up until count equals reload value.
// - One-shot reload raises interrupt pulse and sets count to 0001h.
// - One-shot reload clears enable by hardware, counting stops.
// - One-shot reload drives output opposite level one cycle, then back.
// - Triggered mode idles until selected edge on input pin.
// - After trigger, count prescaled clocks up to reload value.
// - Triggered reload gives one-cycle output pulse, interrupt, count 0001h.
// - Wait for next trigger; triggers during timing are ignored.
// - Continuous reload raises interrupt, count 0001h, keeps counting.
// - Continuous mode toggles output at each reload.
// - Written start count applies to first pass only; later passes from 0001h.
// - Pin counter increments on selected edge of input pin.
// - Prescaler bypassed in both counter modes.
// - Comparator counter counts selected edges of comparator output.
// - Counter reload raises interrupt, count 0001h, resumes, output toggles.
// - Polarity bit sets both edge and initial output level in counters.
// - Timeout lasts (reload - start + 1) times prescale clocks.
// - Prescaler divides by a programmable power of two from 1 to 128.
// - Reload below count: count on through FFFFh, wrap to 0000h.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module rlt_timer
    import rlt_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic              i_ref_clk,    // System clock, 40 MHz
    input  wire logic              i_reset_n,    // Synchronous reset, active low
    input  wire logic              i_clk_en,     // Freezes all state while low
    input  wire logic [ADDR_W-1:0] i_addr,       // Register address
    input  wire logic [DATA_W-1:0] i_wdata,      // Write data
    input  wire logic              i_wr_stb,     // Write strobe
    input  wire logic              i_rd_stb,     // Read strobe
    output logic      [DATA_W-1:0] o_rdata,      // Read data, cycle after strobe
    input  wire logic              i_tmr_in,     // Timer input pin, asynchronous
    input  wire logic              i_cmp_out,    // Comparator output, asynchronous
    output logic                   o_tmr_out,    // Timer output level
    output logic                   o_tmr_out_en, // Output function enabled
    output logic                   o_timer_irq   // One-cycle reload event pulse
);
    generate
        if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
            $error("CNT_W must lie between 2 and the data width");
        end
    endgenerate

    rlt_mode_t            mode_reg;
    logic                 en_reg;
    logic                 pol_reg;
    logic                 oe_reg;
    logic [PRE_SEL_W-1:0] pre_reg;
    logic                 timing_reg;
    logic [CNT_W-1:0]     count_reg;
    logic [CNT_W-1:0]     reload_reg;
    logic                 out_reg;
    logic                 pulse_reg;
    logic                 irq_reg;
    logic [DATA_W-1:0]    rdata_reg;

    logic wr_ctrl;
    logic wr_count;
    logic wr_reload;
    logic start;
    logic count_mode;
    logic shot_mode;
    logic presc_run;
    logic presc_tick;
    logic edge_seen;
    logic arm_edge;
    logic step;
    logic evt;
    logic event_src;

    // Unmapped address falls through: write dropped, read returns zero
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_count  = 1'b0;
        wr_reload = 1'b0;
        if (i_wr_stb && i_addr == ADDR_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (i_wr_stb && i_addr == ADDR_COUNT) begin
            wr_count = 1'b1;
        end else if (i_wr_stb && i_addr == ADDR_RELOAD) begin
            wr_reload = 1'b1;
        end
    end

    assign start      = wr_ctrl & i_wdata[CTRL_EN_BIT] & ~en_reg;
    assign count_mode = (mode_reg == RLT_MODE_PINCNT) || (mode_reg == RLT_MODE_CMPCNT);
    assign shot_mode  = (mode_reg == RLT_MODE_ONESHOT) || (mode_reg == RLT_MODE_TRIG);

    // Source muxed ahead of the synchroniser; any control write changes the mode, even while enabled
    assign event_src = (mode_reg == RLT_MODE_CMPCNT) ? i_cmp_out : i_tmr_in;

    rlt_edge_sync u_edge (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_async   (event_src),
        .i_falling (pol_reg),
        .o_edge    (edge_seen)
    );

    assign presc_run = en_reg & ((mode_reg == RLT_MODE_ONESHOT) ||
                                 (mode_reg == RLT_MODE_CONT) ||
                                 (mode_reg == RLT_MODE_TRIG && timing_reg));

    rlt_prescaler u_presc (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_run     (presc_run),
        .i_sel     (pre_reg),
        .o_tick    (presc_tick)
    );

    assign arm_edge = en_reg & (mode_reg == RLT_MODE_TRIG) & ~timing_reg & edge_seen;
    // Counter modes step on raw edges, no prescaler
    assign step = count_mode ? (en_reg & edge_seen) : presc_tick;
    assign evt  = step & (count_reg == reload_reg);

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            mode_reg <= rlt_mode_t'(CTRL_RST[CTRL_MODE_LSB +: 3]);
            pol_reg  <= CTRL_RST[CTRL_POL_BIT];
            oe_reg   <= CTRL_RST[CTRL_OE_BIT];
            pre_reg  <= CTRL_RST[CTRL_PRE_LSB +: PRE_SEL_W];
        end else if (i_clk_en && wr_ctrl) begin
            mode_reg <= rlt_mode_t'(i_wdata[CTRL_MODE_LSB +: 3]);
            pol_reg  <= i_wdata[CTRL_POL_BIT];
            oe_reg   <= i_wdata[CTRL_OE_BIT];
            pre_reg  <= i_wdata[CTRL_PRE_LSB +: PRE_SEL_W];
        end
    end

    // Software write wins over the hardware stop in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            en_reg <= CTRL_RST[CTRL_EN_BIT];
        end else if (i_clk_en) begin
            if (wr_ctrl) begin
                en_reg <= i_wdata[CTRL_EN_BIT];
            end else if (evt && mode_reg == RLT_MODE_ONESHOT) begin
                en_reg <= 1'b0;
            end
        end
    end

    // Busy drops at the reload, so the next edge may re-arm at once
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            timing_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (!en_reg || mode_reg != RLT_MODE_TRIG || evt) begin
                timing_reg <= 1'b0;
            end else if (arm_edge) begin
                timing_reg <= 1'b1;
            end
        end
    end

    // Software write beats a reload in the same cycle, so a start value is never lost
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            count_reg <= CNT_W'(COUNT_RST);
        end else if (i_clk_en) begin
            if (wr_count) begin
                count_reg <= CNT_W'(i_wdata);
            end else if (evt) begin
                count_reg <= CNT_W'(COUNT_RESTART);
            end else if (step) begin
                count_reg <= count_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            reload_reg <= CNT_W'(RELOAD_RST);
        end else if (i_clk_en && wr_reload) begin
            reload_reg <= CNT_W'(i_wdata);
        end
    end

    // Level is taken at start, so a later polarity change only shows after a pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            out_reg   <= CTRL_RST[CTRL_POL_BIT];
            pulse_reg <= 1'b0;
        end else if (i_clk_en) begin
            pulse_reg <= evt & shot_mode & ~start;
            if (start) begin
                out_reg <= i_wdata[CTRL_POL_BIT];
            end else if (evt) begin
                out_reg <= ~out_reg;
            end else if (pulse_reg) begin
                out_reg <= pol_reg;
            end
        end
    end

    // One-cycle pulse; latching it is left to the interrupt controller
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            irq_reg <= 1'b0;
        end else if (i_clk_en) begin
            irq_reg <= evt;
        end
    end

    // Zero outside a read, so several slaves may share one return bus
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            rdata_reg <= '0;
        end else if (i_clk_en) begin
            rdata_reg <= '0;
            if (i_rd_stb && i_addr == ADDR_CTRL) begin
                rdata_reg[CTRL_EN_BIT]                   <= en_reg;
                rdata_reg[CTRL_MODE_LSB +: 3]            <= mode_reg;
                rdata_reg[CTRL_PRE_LSB +: PRE_SEL_W]     <= pre_reg;
                rdata_reg[CTRL_POL_BIT]                  <= pol_reg;
                rdata_reg[CTRL_OE_BIT]                   <= oe_reg;
                rdata_reg[CTRL_BUSY_BIT]                 <= timing_reg;
            end else if (i_rd_stb && i_addr == ADDR_COUNT) begin
                rdata_reg <= DATA_W'(count_reg);
            end else if (i_rd_stb && i_addr == ADDR_RELOAD) begin
                rdata_reg <= DATA_W'(reload_reg);
            end
        end
    end

    assign o_rdata      = rdata_reg;
    assign o_tmr_out    = out_reg;
    assign o_tmr_out_en = oe_reg;
    assign o_timer_irq  = irq_reg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    // Checks freeze with the clock enable, as the logic they watch does
    default disable iff (!i_reset_n || !i_clk_en);

    chk_oneshot_stop: assert property (
        evt && mode_reg == RLT_MODE_ONESHOT && !wr_ctrl
        |=> !en_reg ##1 (!en_reg || $past(wr_ctrl)))
        else $error("one-shot did not stop after reload");

    chk_reload_count: assert property (
        evt && !wr_count |=> count_reg == CNT_W'(COUNT_RESTART))
        else $error("count not restarted at reload");

    chk_irq_pulse: assert property (
        evt |=> o_timer_irq ##1 (o_timer_irq == $past(evt)))
        else $error("interrupt pulse missing or stretched");

    chk_oneshot_pulse: assert property (
        evt && shot_mode && !start |=> (o_tmr_out != $past(o_tmr_out))
        ##1 ($past(start) || $past(evt) || o_tmr_out == $past(pol_reg)))
        else $error("one-shot output pulse wrong");

    chk_cont_toggle: assert property (
        evt && !shot_mode && !start |=> o_tmr_out != $past(o_tmr_out))
        else $error("output did not toggle at reload");

    chk_trig_idle: assert property (
        en_reg && mode_reg == RLT_MODE_TRIG && !timing_reg && !wr_count && !wr_ctrl
        |=> $stable(count_reg))
        else $error("triggered timer counted without trigger");

    chk_count_step: assert property (
        step && !evt && !wr_count |=> count_reg == $past(count_reg) + CNT_W'(1))
        else $error("count did not advance by one");

    chk_counter_bypass: assert property (
        count_mode && !edge_seen && !wr_count |=> $stable(count_reg))
        else $error("counter mode advanced without an edge");

    chk_trig_ignore: assert property (
        timing_reg && edge_seen && !evt && en_reg && !wr_ctrl |=> timing_reg)
        else $error("trigger during timing was not ignored");

    chk_read_quiet: assert property (
        !i_rd_stb |=> o_rdata == '0)
        else $error("read data not zero outside a read");

    chk_start_level: assert property (
        start |=> o_tmr_out == 1'($past(i_wdata) >> CTRL_POL_BIT))
        else $error("output did not take the polarity level at start");

    chk_trig_arm: assert property (
        arm_edge && !wr_ctrl |=> timing_reg)
        else $error("trigger edge did not start timing");

    chk_trig_rearm: assert property (
        evt && mode_reg == RLT_MODE_TRIG |=> !timing_reg)
        else $error("triggered timer kept timing after reload");

    chk_count_load: assert property (
        wr_count |=> count_reg == CNT_W'($past(i_wdata)))
        else $error("written start count not loaded");

    chk_edge_step: assert property (
        count_mode && en_reg && edge_seen && !evt && !wr_count
        |=> count_reg == $past(count_reg) + CNT_W'(1))
        else $error("counter mode missed an input edge");

    chk_count_wrap: assert property (
        step && !evt && !wr_count && count_reg == '1 |=> count_reg == '0)
        else $error("count did not wrap to zero");

    chk_tick_gate: assert property (
        !presc_run |-> !presc_tick)
        else $error("prescaler ticked while not running");

    chk_irq_quiet: assert property (
        !evt |=> !o_timer_irq)
        else $error("interrupt without reload event");

    chk_cont_runs: assert property (
        evt && mode_reg == RLT_MODE_CONT && !wr_ctrl |=> en_reg)
        else $error("continuous timer stopped at reload");

    chk_out_hold: assert property (
        !evt && !start && !pulse_reg |=> $stable(o_tmr_out))
        else $error("output changed without a reload");

    chk_mode_select: assert property (
        wr_ctrl |=> mode_reg == rlt_mode_t'(3'($past(i_wdata) >> CTRL_MODE_LSB)))
        else $error("mode field not taken from the control write");

    // Main scenarios, one per mode family, plus a trigger ignored while timing
    cov_oneshot_done: cover property (evt && mode_reg == RLT_MODE_ONESHOT);
    cov_trig_done:    cover property (arm_edge ##[1:200] (evt && mode_reg == RLT_MODE_TRIG));
    cov_cont_reload:  cover property (evt && mode_reg == RLT_MODE_CONT ##[1:200] evt);
    cov_pin_reload:   cover property (evt && count_mode);
    cov_trig_ignored: cover property (timing_reg && edge_seen);
endmodule

/* File: rlt_pkg.sv */
// Shared constants, register map and mode encodings of the reload timer
package rlt_pkg;

    localparam int unsigned DATA_W     = 16;
    localparam int unsigned ADDR_W     = 2;
    localparam int unsigned PRE_SEL_W  = 3;
    localparam int unsigned PRE_CNT_W  = 7;

    localparam logic [1:0]  ADDR_CTRL   = 2'h0;
    localparam logic [1:0]  ADDR_COUNT  = 2'h1;
    localparam logic [1:0]  ADDR_RELOAD = 2'h2;

    // Control register field positions
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_PRE_LSB  = 4;
    localparam int unsigned CTRL_POL_BIT  = 7;
    localparam int unsigned CTRL_OE_BIT   = 8;
    localparam int unsigned CTRL_BUSY_BIT = 9;

    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [15:0] COUNT_RST     = 16'h0001;
    localparam logic [15:0] RELOAD_RST    = 16'h0000;
    localparam logic [15:0] COUNT_RESTART = 16'h0001;

    typedef enum logic [2:0] {
        RLT_MODE_ONESHOT = 3'b000,
        RLT_MODE_TRIG    = 3'b001,
        RLT_MODE_CONT    = 3'b010,
        RLT_MODE_PINCNT  = 3'b011,
        RLT_MODE_CMPCNT  = 3'b100
    } rlt_mode_t;

endpackage

/* File: rlt_edge_sync.sv */
// Two-stage synchroniser with selectable edge detector for the event input
`timescale 1ns/1ps
module rlt_edge_sync (
    input  wire logic i_ref_clk,  // System clock
    input  wire logic i_reset_n,  // Synchronous reset, active low
    input  wire logic i_clk_en,   // Freezes state while low
    input  wire logic i_async,    // Asynchronous event source
    input  wire logic i_falling,  // 1 selects falling edge, 0 rising
    output logic      o_edge      // One-cycle pulse per selected edge
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic       hist_reg;
    logic [2:0] fill_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            hist_reg  <= 1'b0;
            fill_reg  <= '0;
        end else if (i_clk_en) begin
            sync1_reg <= i_async;
            sync2_reg <= sync1_reg;
            hist_reg  <= sync2_reg;
            fill_reg  <= {fill_reg[1:0], 1'b1};
        end
    end

    // Only the second stage and its one-cycle history register feed the detector
    // Quiet until the pin level has reached the history, so a pin parked high gives no false edge
    always_comb begin
        if (i_falling) begin
            o_edge = i_clk_en & fill_reg[2] & hist_reg & ~sync2_reg;
        end else begin
            o_edge = i_clk_en & fill_reg[2] & ~hist_reg & sync2_reg;
        end
    end
endmodule

/* File: rlt_prescaler.sv */
// Power-of-two prescaler producing one tick per divided period
`timescale 1ns/1ps
module rlt_prescaler
    import rlt_pkg::*;
(
    input  wire logic                 i_ref_clk,  // System clock
    input  wire logic                 i_reset_n,  // Synchronous reset, active low
    input  wire logic                 i_clk_en,   // Freezes state while low
    input  wire logic                 i_run,      // Count while high, clear while low
    input  wire logic [PRE_SEL_W-1:0] i_sel,      // Divide by two to the power of i_sel
    output logic                      o_tick      // One-cycle tick per period
);
    logic [PRE_CNT_W-1:0] div_reg;
    logic [PRE_CNT_W-1:0] limit;

    assign limit  = PRE_CNT_W'((8'h01 << i_sel) - 8'h01);
    assign o_tick = i_clk_en & i_run & (div_reg == limit);

    // Cleared while stopped so every start begins a full period
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            div_reg <= '0;
        end else if (i_clk_en) begin
            if (!i_run || div_reg == limit) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + PRE_CNT_W'(1);
            end
        end
    end
endmodule

/* File: rlt_event_src.sv */
// Far-side model: timer input pin and comparator output
`timescale 1ns/1ps
module rlt_event_src (
    input  wire logic i_ref_clk,  // System clock
    output logic      o_tmr_in,   // Timer input pin level
    output logic      o_cmp_out   // Comparator output level
);
    initial begin
        o_tmr_in  = 1'b0;
        o_cmp_out = 1'b0;
    end

    // Park both sources before a mode is enabled
    task automatic set_idle(input logic lvl);
        @(posedge i_ref_clk);
        o_tmr_in  <= lvl;
        o_cmp_out <= lvl;
    endtask

    // Unselected source chatters, so a wrong source mux shows up
    task automatic pulses(input bit on_cmp, input int num, input logic idle);
        for (int i = 0; i < 2 * num; i++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge i_ref_clk);
                if (on_cmp) begin
                    o_cmp_out <= (i % 2 == 0) ? ~idle : idle;
                    o_tmr_in  <= ~o_tmr_in;
                end else begin
                    o_tmr_in  <= (i % 2 == 0) ? ~idle : idle;
                    o_cmp_out <= ~o_cmp_out;
                end
            end
        end
        set_idle(idle);
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the reload timer modes
`timescale 1ns/1ps
module testbench;
    import rlt_pkg::*;
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              tin;
    logic              cin;
    logic              tout;
    logic              tout_en;
    logic              irq;
    logic              o1;
    logic              ce;
    int                errors = 0;
    int                compares = 0;
    int                cyc = 0;
    int                irqs = 0;
    int                t0;

    rlt_timer rlt_timer_inst (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr_stb(wr), .i_rd_stb(rd), .o_rdata(rdata),
        .i_tmr_in(tin), .i_cmp_out(cin), .o_tmr_out(tout), .o_tmr_out_en(tout_en),
        .o_timer_irq(irq));

    rlt_event_src rlt_event_src_inst (.i_ref_clk(clk), .o_tmr_in(tin), .o_cmp_out(cin));

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [1:0] a, input logic [15:0] exp, input string name);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    // Bounded so a lost event still reaches the report
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 2000);
        if (irq !== 1'b1) begin
            errors++;
            $display("Error irq expected 1 seen %b", irq);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1)
            irqs <= irqs + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            $display("Error timeout expected 0 seen %0d", cyc);
            test_done();
        end
    end

    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
        ce    = 1'b1;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("out", 16'h0000, {14'h0, tout_en, tout});
        bus_rd(ADDR_CTRL, CTRL_RST, "ctrl");
        bus_rd(ADDR_COUNT, 16'h0001, "count");
        bus_wr(2'h3, 16'hFFFF);
        bus_rd(2'h3, 16'h0000, "unmapped");
        bus_rd(ADDR_RELOAD, 16'h0000, "reload");
        $display("test reset done");

        bus_wr(ADDR_RELOAD, 16'h0003);
        bus_wr(ADDR_CTRL, 16'h0101);
        t0 = cyc;
        wait_irq();
        chk("oneshot time", 16'h0003, 16'(cyc - t0));
        chk("pulse", 16'h0003, {14'h0, tout_en, tout});
        @(posedge clk);
        #1;
        chk("pulse end", 16'h0000, {14'h0, irq, tout});
        bus_rd(ADDR_CTRL, 16'h0100, "self stop");
        bus_rd(ADDR_COUNT, 16'h0001, "count");
        t0 = irqs;
        repeat (20) @(posedge clk);
        #1;
        chk("stopped", 16'(t0), 16'(irqs));
        // Flip the level after start for a lasting change
        bus_wr(ADDR_CTRL, 16'h0101);
        bus_wr(ADDR_CTRL, 16'h0181);
        wait_irq();
        @(posedge clk);
        #1;
        chk("lasting out", 16'h0001, {15'h0, tout});
        $display("test one-shot done");

        for (int n = 0; n < 8; n++) begin
            bus_wr(ADDR_CTRL, 16'h0000);
            bus_wr(ADDR_COUNT, 16'h0002);
            bus_wr(ADDR_RELOAD, 16'h0003);
            bus_wr(ADDR_CTRL, 16'h0105 | 16'(n << 4));
            wait_irq();
            wait_irq();
            t0 = cyc;
            o1 = tout;
            wait_irq();
            chk("period", 16'(3 << n), 16'(cyc - t0));
            chk("toggle", {15'h0, ~o1}, {15'h0, tout});
        end
        bus_wr(ADDR_CTRL, 16'h0000);
        $display("test continuous done");

        rlt_event_src_inst.set_idle(1'b1);
        bus_wr(ADDR_RELOAD, 16'h003C);
        bus_wr(ADDR_COUNT, 16'h0001);
        bus_wr(ADDR_CTRL, 16'h0183);
        t0 = irqs;
        repeat (30) @(posedge clk);
        #1;
        chk("idle", 16'(t0), 16'(irqs));
        rlt_event_src_inst.pulses(1'b0, 3, 1'b1);
        bus_rd(ADDR_CTRL, 16'h0383, "busy");
        wait_irq();
        chk("trig pulse", 16'h0000, {15'h0, tout});
        repeat (80) @(posedge clk);
        #1;
        chk("ignored", 16'(t0 + 1), 16'(irqs));
        bus_rd(ADDR_CTRL, 16'h0183, "rearm");
        rlt_event_src_inst.pulses(1'b0, 1, 1'b1);
        wait_irq();
        repeat (2) @(posedge clk);
        #1;
        chk("retrigger", 16'(t0 + 2), 16'(irqs));
        $display("test triggered done");

        // Prescale 128 set on purpose: counting must still be per edge
        for (int m = 0; m < 2; m++) begin
            bus_wr(ADDR_CTRL, 16'h0000);
            rlt_event_src_inst.set_idle(m[0]);
            bus_wr(ADDR_COUNT, 16'h0001);
            bus_wr(ADDR_RELOAD, 16'h0003);
            bus_wr(ADDR_CTRL, 16'h0171 | 16'(m << 7) | 16'((3 + m) << 1));
            chk("start level", {15'h0, m[0]}, {15'h0, tout});
            t0 = irqs;
            rlt_event_src_inst.pulses(m[0], 2, m[0]);
            repeat (6) @(posedge clk);
            bus_rd(ADDR_COUNT, 16'h0003, "events");
            rlt_event_src_inst.pulses(m[0], 1, m[0]);
            repeat (6) @(posedge clk);
            #1;
            chk("reload irq", 16'(t0 + 1), 16'(irqs));
            chk("toggle", {15'h0, ~m[0]}, {15'h0, tout});
            bus_rd(ADDR_COUNT, 16'h0001, "restart");
        end
        bus_wr(ADDR_CTRL, 16'h0000);
        rlt_event_src_inst.set_idle(1'b0);
        bus_wr(ADDR_COUNT, 16'hFFFE);
        bus_wr(ADDR_RELOAD, 16'h0002);
        bus_wr(ADDR_CTRL, 16'h0007);
        rlt_event_src_inst.pulses(1'b0, 2, 1'b0);
        repeat (6) @(posedge clk);
        bus_rd(ADDR_COUNT, 16'h0000, "wrap");
        $display("test counters done");

        // Strobes and pin edges are lost while the clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        bus_wr(ADDR_COUNT, 16'h1234);
        rlt_event_src_inst.pulses(1'b0, 1, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        bus_rd(ADDR_COUNT, 16'h0000, "frozen");
        $display("test clock enable done");
        test_done();
    end
endmodule
